// *** hdl/dtc_defs.svh ***
// Constants of the dual timer/counter: register indices, field positions,
// reset values and the prescaler ratio.
// Assumes inclusion by bare name from the design and bench files of this block.
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// Register indices; the APB byte address is four times the index.
`define DTC_IDX_RUN_CTRL   8'h88
`define DTC_IDX_MODE_CTRL  8'h89
`define DTC_IDX_T0_LOW     8'h8a
`define DTC_IDX_T1_LOW     8'h8b
`define DTC_IDX_T0_HIGH    8'h8c
`define DTC_IDX_T1_HIGH    8'h8d

// Field positions of timer_mode_control.
`define DTC_T1_GATE_BIT    7
`define DTC_T1_SRC_BIT     6
`define DTC_T1_MODE_HI     5
`define DTC_T1_MODE_LO     4
`define DTC_T0_GATE_BIT    3
`define DTC_T0_SRC_BIT     2
`define DTC_T0_MODE_HI     1
`define DTC_T0_MODE_LO     0

// Field positions of the run and flag register.
`define DTC_T1_FLAG_BIT    7
`define DTC_T1_RUN_BIT     6
`define DTC_T0_FLAG_BIT    5
`define DTC_T0_RUN_BIT     4

// Reset values.
`define DTC_RESET_BYTE     8'h00

// System clocks per timer tick of the divided-down clock.
`define DTC_PRESCALE_DIV   4'd12

`endif

// *** hdl/dtc_pkg.sv ***
// Types shared by the dual timer/counter modules.
// Assumes nothing beyond a SystemVerilog compiler.
package dtc_pkg;

  // Counting modes selected by the two mode bits of each timer.
  typedef enum logic [1:0] {
    DTC_MODE_13BIT  = 2'b00,
    DTC_MODE_16BIT  = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT  = 2'b11
  } dtc_mode_t;

endpackage

// *** hdl/dtc_ctl_if.sv ***
// Carrier between the timer core and one count gating unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface dtc_ctl_if;
  logic gate;
  logic src;
  logic run;
  logic irq_pin;
  logic event_pin;
  logic tick;
  logic cnt_en;

  modport core (output gate, src, run, irq_pin, event_pin, tick,
                input  cnt_en);
  modport unit (input  gate, src, run, irq_pin, event_pin, tick,
                output cnt_en);
endinterface

`default_nettype wire

// *** hdl/dtc_count_gate.sv ***
// Count enable of one timer: run, gate, source select and event edge.
// Assumes the event and gate pins are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module dtc_count_gate (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic arst_n,
  // Controls from the timer core.
  dtc_ctl_if.unit   ctl
);

  logic event_prev;
  wire  event_fall;
  wire  gate_open;
  wire  source_pulse;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      event_prev <= 1'b0;
    end else begin
      event_prev <= ctl.event_pin;
    end
  end

  // A falling edge is a high sample followed by a low one.
  assign event_fall   = event_prev & ~ctl.event_pin;
  // With the gate set the interrupt pin must also be high.
  assign gate_open    = ~ctl.gate | ctl.irq_pin;
  assign source_pulse = ctl.src ? event_fall : ctl.tick;
  assign ctl.cnt_en   = ctl.run & gate_open & source_pulse;

endmodule // dtc_count_gate

`default_nettype wire

// *** hdl/dtc_timer_core.sv ***
// Dual 8-bit-paired timer/counter with mode control, reached over APB.
// Assumes an APB master on clk; pins are synchronous to clk.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

`include "dtc_defs.svh"

// Behaviour
// - Mode register bits 7..0: tmr1_gate_enable, source1, mode1 pair, tmr0_gate_enable, source0, mode0 pair.
// - Tmr1_gate_enable clear: timer 1 runs whenever its run bit is set; the code holds timer 1 while its mode code is 11.
// - Tmr1_gate_enable set: timer 1 runs only while interrupt 1 pin high and run set.
// - Source1 clear: timer 1 counts the divided-down system clock.
// - Source1 set: timer 1 counts falling edges on its event pin.
// - Mode code 01 joins high and low bytes into one 16-bit counter.
// - Mode code 10: low byte counts, reloads from high byte on overflow.
// - Timer 0 low and high bytes are read/write registers, zero at reset.
// - Timer 1 low and high bytes are read/write registers, zero at reset.
// - Overflow sets the timer flag; interrupt vectoring clears it. Timer 1's overflow sets no flag while timer 0 is in mode 11.
// - Each timer has a run bit that starts and stops it.
module dtc_timer_core (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        arst_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Gate and event pins.
  input  wire logic        ext_irq_a_pin,
  input  wire logic        ext_irq_b_pin,
  input  wire logic        first_event_pin,
  input  wire logic        second_event_pin,
  // Interrupt controller side.
  input  wire logic        tmr0_vector_ack,
  input  wire logic        tmr1_vector_ack,
  output var  logic        tmr0_overflow_flag,
  output var  logic        tmr1_overflow_flag
);

  // ****************************************************************
  // Step function
  // ****************************************************************

  // Returns {overflow, high, low} after one count in the given mode.
  function automatic logic [16:0] dtc_step(
    input dtc_pkg::dtc_mode_t mode,
    input logic [7:0]         high,
    input logic [7:0]         low
  );
    logic [13:0] wide13;
    logic [16:0] wide16;
    logic [8:0]  wide8;
    wide13 = {1'b0, high, low[4:0]} + 14'h0001;
    wide16 = {1'b0, high, low} + 17'h00001;
    wide8  = {1'b0, low} + 9'h001;
    case (mode)
      dtc_pkg::DTC_MODE_13BIT: begin
        dtc_step = {wide13[13], wide13[12:5], low[7:5], wide13[4:0]};
      end
      dtc_pkg::DTC_MODE_16BIT: begin
        dtc_step = wide16;
      end
      dtc_pkg::DTC_MODE_RELOAD: begin
        if (wide8[8]) begin
          dtc_step = {1'b1, high, high};
        end else begin
          dtc_step = {1'b0, high, wide8[7:0]};
        end
      end
      default: begin
        dtc_step = {wide8[8], high, wide8[7:0]};
      end
    endcase
  endfunction

  // ****************************************************************
  // Register storage
  // ****************************************************************

  logic [7:0] timer_mode_control;
  logic [7:0] timer0_count_low;
  logic [7:0] timer0_count_high;
  logic [7:0] timer1_count_low;
  logic [7:0] timer1_count_high;
  logic       tmr0_run;
  logic       tmr1_run;
  logic [3:0] prescale_cnt;

  // ****************************************************************
  // Mode fields
  // ****************************************************************

  wire                tmr1_gate_enable;
  wire                tmr1_source_select;
  wire                tmr1_mode_upper;
  wire                tmr1_mode_lower;
  wire                tmr0_gate_enable;
  wire                tmr0_source_select;
  wire                tmr0_mode_upper;
  wire                tmr0_mode_lower;
  dtc_pkg::dtc_mode_t t0_mode;
  dtc_pkg::dtc_mode_t t1_mode;

  assign tmr1_gate_enable   = timer_mode_control[`DTC_T1_GATE_BIT];
  assign tmr1_source_select = timer_mode_control[`DTC_T1_SRC_BIT];
  assign tmr1_mode_upper    = timer_mode_control[`DTC_T1_MODE_HI];
  assign tmr1_mode_lower    = timer_mode_control[`DTC_T1_MODE_LO];
  assign tmr0_gate_enable   = timer_mode_control[`DTC_T0_GATE_BIT];
  assign tmr0_source_select = timer_mode_control[`DTC_T0_SRC_BIT];
  assign tmr0_mode_upper    = timer_mode_control[`DTC_T0_MODE_HI];
  assign tmr0_mode_lower    = timer_mode_control[`DTC_T0_MODE_LO];
  assign t1_mode = dtc_pkg::dtc_mode_t'({tmr1_mode_upper, tmr1_mode_lower});
  assign t0_mode = dtc_pkg::dtc_mode_t'({tmr0_mode_upper, tmr0_mode_lower});

  // ****************************************************************
  // APB decode
  // ****************************************************************

  wire [7:0] reg_idx;
  wire       addr_ok;
  wire       hit_run;
  wire       hit_mode;
  wire       hit_t0_low;
  wire       hit_t1_low;
  wire       hit_t0_high;
  wire       hit_t1_high;
  wire       hit_any;
  wire       access;
  wire       wr_en;
  wire       setup;
  wire [7:0] wdata;
  wire [7:0] run_ctrl_view;
  wire [7:0] rd_byte;

  assign reg_idx     = paddr[9:2];
  assign addr_ok     = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
  assign hit_run     = addr_ok && (reg_idx == `DTC_IDX_RUN_CTRL);
  assign hit_mode    = addr_ok && (reg_idx == `DTC_IDX_MODE_CTRL);
  assign hit_t0_low  = addr_ok && (reg_idx == `DTC_IDX_T0_LOW);
  assign hit_t1_low  = addr_ok && (reg_idx == `DTC_IDX_T1_LOW);
  assign hit_t0_high = addr_ok && (reg_idx == `DTC_IDX_T0_HIGH);
  assign hit_t1_high = addr_ok && (reg_idx == `DTC_IDX_T1_HIGH);
  assign hit_any     = hit_run | hit_mode | hit_t0_low | hit_t1_low
                     | hit_t0_high | hit_t1_high;
  assign access      = psel & penable;
  assign setup       = psel & ~penable;
  assign wr_en       = access & pwrite & hit_any;
  assign wdata       = pwdata[7:0];

  // Zero wait states; an unmapped or misaligned address answers an error.
  assign pready  = 1'b1;
  assign pslverr = access & ~hit_any;

  assign run_ctrl_view = {tmr1_overflow_flag, tmr1_run,
                          tmr0_overflow_flag, tmr0_run, 4'h0};

  assign rd_byte = hit_run     ? run_ctrl_view      :
                   hit_mode    ? timer_mode_control :
                   hit_t0_low  ? timer0_count_low   :
                   hit_t0_high ? timer0_count_high  :
                   hit_t1_low  ? timer1_count_low   :
                   hit_t1_high ? timer1_count_high  :
                   8'h00;

  // Read data is captured in the setup cycle and stands during access.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // ****************************************************************
  // Prescaler
  // ****************************************************************

  wire       tick;
  wire [3:0] next_prescale_cnt;

  assign tick              = (prescale_cnt == `DTC_PRESCALE_DIV - 4'd1);
  assign next_prescale_cnt = tick ? 4'h0 : prescale_cnt + 4'h1;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prescale_cnt <= 4'h0;
    end else begin
      prescale_cnt <= next_prescale_cnt;
    end
  end

  // ****************************************************************
  // Count gating units
  // ****************************************************************

  dtc_ctl_if ctl0 ();
  dtc_ctl_if ctl1 ();

  assign ctl0.gate      = tmr0_gate_enable;
  assign ctl0.src       = tmr0_source_select;
  assign ctl0.run       = tmr0_run;
  assign ctl0.irq_pin   = ext_irq_a_pin;
  assign ctl0.event_pin = first_event_pin;
  assign ctl0.tick      = tick;

  assign ctl1.gate      = tmr1_gate_enable;
  assign ctl1.src       = tmr1_source_select;
  assign ctl1.run       = tmr1_run;
  assign ctl1.irq_pin   = ext_irq_b_pin;
  assign ctl1.event_pin = second_event_pin;
  assign ctl1.tick      = tick;

  dtc_count_gate u_tmr0_gate_enable (
    .clk    (clk),
    .arst_n (arst_n),
    .ctl    (ctl0.unit)
  );

  dtc_count_gate u_tmr1_gate_enable (
    .clk    (clk),
    .arst_n (arst_n),
    .ctl    (ctl1.unit)
  );

  // ****************************************************************
  // Count paths
  // ****************************************************************

  wire        t0_split;
  wire        t0_en;
  wire        t1_en;
  wire        th0_split_en;
  wire        th0_split_ovf;
  wire [16:0] step0;
  wire [16:0] step1;
  wire        ovf0;
  wire        ovf1;
  wire [7:0]  next_t0_low;
  wire [7:0]  next_t0_high;
  wire [7:0]  next_t1_low;
  wire [7:0]  next_t1_high;

  assign t0_split = (t0_mode == dtc_pkg::DTC_MODE_SPLIT);
  assign t0_en    = ctl0.cnt_en;
  // Timer 1 in mode 11 holds its count.
  assign t1_en    = ctl1.cnt_en && (t1_mode != dtc_pkg::DTC_MODE_SPLIT);

  assign step0 = dtc_step(t0_mode, timer0_count_high, timer0_count_low);
  assign step1 = dtc_step(t1_mode, timer1_count_high, timer1_count_low);

  // The split high byte is an 8-bit timer run by timer 1's run bit.
  assign th0_split_en  = t0_split & tmr1_run & tick;
  assign th0_split_ovf = th0_split_en && (timer0_count_high == 8'hff);

  assign ovf0 = t0_en & step0[16];
  // While timer 0 is split, timer 1 keeps counting without a flag.
  assign ovf1 = (t1_en & step1[16] & ~t0_split) | th0_split_ovf;

  // A software write to a count byte wins over the count in that cycle.
  assign next_t0_low  = (wr_en && hit_t0_low)  ? wdata :
                        t0_en ? step0[7:0] : timer0_count_low;
  assign next_t0_high = (wr_en && hit_t0_high) ? wdata :
                        th0_split_en ? timer0_count_high + 8'h01 :
                        t0_en ? step0[15:8] : timer0_count_high;
  assign next_t1_low  = (wr_en && hit_t1_low)  ? wdata :
                        t1_en ? step1[7:0] : timer1_count_low;
  assign next_t1_high = (wr_en && hit_t1_high) ? wdata :
                        t1_en ? step1[15:8] : timer1_count_high;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer0_count_low  <= `DTC_RESET_BYTE;
      timer0_count_high <= `DTC_RESET_BYTE;
      timer1_count_low  <= `DTC_RESET_BYTE;
      timer1_count_high <= `DTC_RESET_BYTE;
    end else begin
      timer0_count_low  <= next_t0_low;
      timer0_count_high <= next_t0_high;
      timer1_count_low  <= next_t1_low;
      timer1_count_high <= next_t1_high;
    end
  end

  // ****************************************************************
  // Mode, run bits and overflow flags
  // ****************************************************************

  wire wr_run;
  wire next_tmr0_run;
  wire next_tmr1_run;
  wire keep_flag0;
  wire keep_flag1;
  wire next_flag0;
  wire next_flag1;

  assign wr_run        = wr_en & hit_run;
  assign next_tmr0_run = wr_run ? wdata[`DTC_T0_RUN_BIT] : tmr0_run;
  assign next_tmr1_run = wr_run ? wdata[`DTC_T1_RUN_BIT] : tmr1_run;

  // Vectoring clears a flag, software may write it, an overflow sets it
  // and the set wins over either clear.
  assign keep_flag0 = wr_run ? wdata[`DTC_T0_FLAG_BIT]
                             : (tmr0_overflow_flag & ~tmr0_vector_ack);
  assign keep_flag1 = wr_run ? wdata[`DTC_T1_FLAG_BIT]
                             : (tmr1_overflow_flag & ~tmr1_vector_ack);
  assign next_flag0 = keep_flag0 | ovf0;
  assign next_flag1 = keep_flag1 | ovf1;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_mode_control <= `DTC_RESET_BYTE;
      tmr0_run           <= 1'b0;
      tmr1_run           <= 1'b0;
      tmr0_overflow_flag <= 1'b0;
      tmr1_overflow_flag <= 1'b0;
    end else begin
      if (wr_en && hit_mode) begin
        timer_mode_control <= wdata;
      end
      tmr0_run           <= next_tmr0_run;
      tmr1_run           <= next_tmr1_run;
      tmr0_overflow_flag <= next_flag0;
      tmr1_overflow_flag <= next_flag1;
    end
  end

endmodule // dtc_timer_core

`default_nettype wire

// *** tb/dtc_timer_core_checker.sv ***
// Port assertions of the dual timer/counter.
// Assumes a bind onto dtc_timer_core from the bench top.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_defs.svh"

module dtc_timer_core_checker (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        arst_n,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and flags.
  input wire logic        first_event_pin,
  input wire logic        second_event_pin,
  input wire logic        tmr0_vector_ack,
  input wire logic        tmr1_vector_ack,
  input wire logic        tmr0_overflow_flag,
  input wire logic        tmr1_overflow_flag
);
  // ****************************************
  // Mirror of the prescaler and event edges.
  // ****************************************
  logic [3:0] pc;
  logic       p0;
  logic       p1;
  wire logic  tick   = pc == 4'hb;
  wire logic  acc    = psel && penable;
  wire logic  ok_a   = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0 &&
                       paddr[9:2] >= `DTC_IDX_RUN_CTRL &&
                       paddr[9:2] <= `DTC_IDX_T1_HIGH;
  wire logic  wr_run = acc && pwrite &&
                       paddr == {2'h0, `DTC_IDX_RUN_CTRL, 2'h0};
  wire logic  e0     = p0 && !first_event_pin;
  wire logic  e1     = p1 && !second_event_pin;
  wire logic  set0   = wr_run || tick || e0;
  wire logic  set1   = wr_run || tick || e1;
  wire logic  clr0   = wr_run || tmr0_vector_ack;
  wire logic  clr1   = wr_run || tmr1_vector_ack;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc <= 4'h0;
      p0 <= 1'b1;
      p1 <= 1'b1;
    end else begin
      pc <= tick ? 4'h0 : pc + 4'h1;
      p0 <= first_event_pin;
      p1 <= second_event_pin;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_PREADY: assert property (pready)
    else $error("pready low");
  AST_ERR_BAD: assert property (acc && !ok_a |-> pslverr)
    else $error("bad address not refused");
  AST_ERR_OK: assert property (acc && ok_a |-> !pslverr)
    else $error("good address refused");
  AST_ERR_IDLE: assert property (!acc |-> !pslverr)
    else $error("error outside access");
  AST_RD_HIGH: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_RD_BAD: assert property (acc && !ok_a && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  AST_F0_RISE: assert property ($rose(tmr0_overflow_flag) |-> $past(set0))
    else $error("flag 0 set without cause");
  AST_F1_RISE: assert property ($rose(tmr1_overflow_flag) |-> $past(set1))
    else $error("flag 1 set without cause");
  AST_F0_FALL: assert property ($fell(tmr0_overflow_flag) |-> $past(clr0))
    else $error("flag 0 cleared without cause");
  AST_F0_ACK: assert property (tmr0_vector_ack && !set0 |=> !tmr0_overflow_flag)
    else $error("flag 0 kept after ack");
  AST_F1_ACK: assert property (tmr1_vector_ack && !set1 ##1 1'b1
    |-> !tmr1_overflow_flag) else $error("flag 1 kept after ack");
  AST_F1_FALL: assert property ($fell(tmr1_overflow_flag) |-> $past(clr1))
    else $error("flag 1 cleared without cause");

  cover property ($rose(tmr0_overflow_flag) && !$past(wr_run));
  cover property (acc && pslverr);
  cover property (tmr1_vector_ack && tmr1_overflow_flag);
endmodule // dtc_timer_core_checker

`default_nettype wire

// *** tb/dtc_pin_model.sv ***
// Far side of the timer core: gate pins and event pins.
// Assumes requests from the bench change just after a rising clk edge.
`timescale 1ns/1ps
`default_nettype none

module dtc_pin_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Requests from the bench.
  input  wire logic [1:0] gate_lvl,
  input  wire logic [1:0] evt_req,
  // Pins of the timer core.
  output logic            ext_irq_a_pin,
  output logic            ext_irq_b_pin,
  output logic            first_event_pin,
  output logic            second_event_pin
);
  // ****************************************
  // Event pins idle high and dip low per request.
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_irq_a_pin    <= 1'b0;
      ext_irq_b_pin    <= 1'b0;
      first_event_pin  <= 1'b1;
      second_event_pin <= 1'b1;
    end else begin
      ext_irq_a_pin    <= gate_lvl[0];
      ext_irq_b_pin    <= gate_lvl[1];
      first_event_pin  <= !evt_req[0];
      second_event_pin <= !evt_req[1];
    end
  end
endmodule // dtc_pin_model

`default_nettype wire

// *** tb/dtc_timer_core_test.sv ***
// Self-checking bench of the dual timer/counter over APB.
// Assumes the design files and dtc_defs.svh are on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_defs.svh"

module dtc_timer_core_test;
  logic        clk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq_a;
  logic        irq_b;
  logic        ev0;
  logic        ev1;
  logic [1:0]  vack;
  logic        f0;
  logic        f1;
  logic [1:0]  gate_lvl;
  logic [1:0]  evt_req;
  logic [31:0] q;
  logic        e;
  int          miscompares;
  int          checks_done;
  int          cycles;

  dtc_timer_core uut (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_a_pin(irq_a), .ext_irq_b_pin(irq_b), .first_event_pin(ev0),
    .second_event_pin(ev1), .tmr0_vector_ack(vack[0]),
    .tmr1_vector_ack(vack[1]), .tmr0_overflow_flag(f0),
    .tmr1_overflow_flag(f1));

  dtc_pin_model pins (.clk(clk), .arst_n(arst_n), .gate_lvl(gate_lvl),
    .evt_req(evt_req), .ext_irq_a_pin(irq_a), .ext_irq_b_pin(irq_b),
    .first_event_pin(ev0), .second_event_pin(ev1));

  // ****************************************
  // Bus, pin and report tasks.
  // ****************************************
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input int i, input logic [7:0] d);
    bus(1'b1, {2'h0, 8'(i), 2'h0}, d);
  endtask

  task automatic chk(input int i, input logic [7:0] d);
    bus(1'b0, {2'h0, 8'(i), 2'h0}, 8'h00);
    cmp(q, {24'h0, d});
    cmp({31'h0, e}, 32'h0);
  endtask

  // The run write lands ticks*12 edges before the stop write.
  task automatic go(input logic [7:0] run, input int ticks);
    wr(`DTC_IDX_RUN_CTRL, run);
    repeat (`DTC_PRESCALE_DIV * ticks - 3) @(posedge clk);
  endtask

  // Stopping sets both flags so that the ack alone must clear them.
  task automatic halt_ack();
    wr(`DTC_IDX_RUN_CTRL, 8'ha0);
    @(posedge clk);
    vack <= 2'b11;
    repeat (2) @(posedge clk);
    vack <= 2'b00;
    @(posedge clk);
    cmp({30'h0, f1, f0}, 32'h0);
  endtask

  task automatic clr();
    for (int i = `DTC_IDX_T0_LOW; i <= `DTC_IDX_T1_HIGH; i++) wr(i, 8'h00);
  endtask

  task automatic pulse(input int i, input int n);
    repeat (n) begin
      @(posedge clk);
      evt_req[i] <= 1'b1;
      @(posedge clk);
      evt_req[i] <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      $display("ERROR %0t timeout", $time);
      test_done();
    end
  end

  // ****************************************
  // Test sequence.
  // ****************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {gate_lvl, evt_req, vack} = '0;
    {miscompares, checks_done, cycles} = '0;
    arst_n = 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = `DTC_IDX_RUN_CTRL; i <= `DTC_IDX_T1_HIGH; i++)
      chk(i, 8'h00);
    $display("test reset values done");
    for (int i = `DTC_IDX_MODE_CTRL; i <= `DTC_IDX_T1_HIGH; i++)
      wr(i, 8'(i + 'h21));
    for (int i = `DTC_IDX_MODE_CTRL; i <= `DTC_IDX_T1_HIGH; i++)
      chk(i, 8'(i + 'h21));
    bus(1'b0, 12'h240, 8'h00);
    cmp({e, q[30:0]}, 32'h80000000);
    bus(1'b1, 12'h225, 8'h11);
    cmp({31'h0, e}, 32'h1);
    $display("test register access done");
    for (int t = 0; t < 2; t++) begin
      wr(`DTC_IDX_MODE_CTRL, t ? 8'h20 : 8'h02);
      wr(`DTC_IDX_T0_HIGH + t, 8'hfe);
      wr(`DTC_IDX_T0_LOW + t, 8'hff);
      go(t ? 8'h40 : 8'h10, 3);
      cmp({31'h0, t ? f1 : f0}, 32'h1);
      halt_ack();
      chk(`DTC_IDX_T0_LOW + t, 8'hfe);
      chk(`DTC_IDX_T0_HIGH + t, 8'hfe);
    end
    $display("test reload done");
    wr(`DTC_IDX_MODE_CTRL, 8'h11);
    wr(`DTC_IDX_T1_HIGH, 8'h12);
    wr(`DTC_IDX_T1_LOW, 8'hfe);
    wr(`DTC_IDX_T0_HIGH, 8'hff);
    wr(`DTC_IDX_T0_LOW, 8'hff);
    go(8'h50, 3);
    cmp({30'h0, f1, f0}, 32'h1);
    halt_ack();
    chk(`DTC_IDX_T1_LOW, 8'h01);
    chk(`DTC_IDX_T1_HIGH, 8'h13);
    chk(`DTC_IDX_T0_LOW, 8'h02);
    chk(`DTC_IDX_T0_HIGH, 8'h00);
    $display("test sixteen bit done");
    gate_lvl <= 2'b01;
    wr(`DTC_IDX_MODE_CTRL, 8'h99);
    clr();
    go(8'h50, 2);
    halt_ack();
    chk(`DTC_IDX_T0_LOW, 8'h02);
    chk(`DTC_IDX_T1_LOW, 8'h00);
    gate_lvl <= 2'b10;
    go(8'h50, 1);
    halt_ack();
    chk(`DTC_IDX_T0_LOW, 8'h02);
    chk(`DTC_IDX_T1_LOW, 8'h01);
    $display("test gate done");
    gate_lvl <= 2'b00;
    wr(`DTC_IDX_MODE_CTRL, 8'h55);
    clr();
    wr(`DTC_IDX_RUN_CTRL, 8'h50);
    pulse(1, 3);
    pulse(0, 2);
    halt_ack();
    chk(`DTC_IDX_T1_LOW, 8'h03);
    chk(`DTC_IDX_T0_LOW, 8'h02);
    $display("test event count done");
    wr(`DTC_IDX_MODE_CTRL, 8'h03);
    wr(`DTC_IDX_T0_HIGH, 8'hff);
    wr(`DTC_IDX_T0_LOW, 8'h55);
    go(8'h40, 2);
    cmp({30'h0, f1, f0}, 32'h2);
    halt_ack();
    chk(`DTC_IDX_T0_HIGH, 8'h01);
    chk(`DTC_IDX_T0_LOW, 8'h55);
    chk(`DTC_IDX_T1_LOW, 8'h05);
    $display("test split done");
    test_done();
  end
endmodule // dtc_timer_core_test

bind dtc_timer_core dtc_timer_core_checker chk_i (.clk(clk),
  .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .first_event_pin(first_event_pin), .second_event_pin(second_event_pin),
  .tmr0_vector_ack(tmr0_vector_ack), .tmr1_vector_ack(tmr1_vector_ack),
  .tmr0_overflow_flag(tmr0_overflow_flag),
  .tmr1_overflow_flag(tmr1_overflow_flag));

`default_nettype wire
